// *** mprs_consts.vh ***
// Constants for the module power and reset sequencer
`ifndef MPRS_CONSTS_VH
`define MPRS_CONSTS_VH
`define MPRS_CLK_MHZ 125
`define MPRS_PWRUP_MS 2000
`define MPRS_RST_MIN_MS 10
`define MPRS_RST_PWRUP_MS 38
`define MPRS_CYC_PER_MS (`MPRS_CLK_MHZ * 1000)
`define MPRS_CNT_W 32
`define MPRS_ST_OFF 3'h0
`define MPRS_ST_POWERING 3'h1
`define MPRS_ST_ON 3'h2
`define MPRS_ST_RESETTING 3'h3
`define MPRS_ST_RESTART 3'h4
`define MPRS_ST_WAIT_REL 3'h5
`endif

// *** mprs_host_model.sv ***
// Host model: drives the power request and reset lines low when pulled, high otherwise
`timescale 1ns/1ns
module mprs_host_model
(
   input wire pull_req,
   input wire pull_rst,
   output wire power_on_request_n,
   output wire external_reset_n
);
   // Host drives each line high when not pulling it low, so no pull-up sets the idle level
   assign power_on_request_n = pull_req ? 1'b0 : 1'b1;
   assign external_reset_n = pull_rst ? 1'b0 : 1'b1;
endmodule

// *** mprs_low_timer.v ***
// Counts how long a synchronised active-low input has stayed low
`timescale 1ns/1ns
module mprs_low_timer
#(
   parameter W = 32
)
(
   input wire clk,
   input wire rst_n,
   input wire level_n,
   input wire [W-1:0] limit,
   output reg reached,
   output reg fell
);
   reg [W-1:0] count;
   reg prev_n;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count <= {W{1'b0}};
         reached <= 1'b0;
         fell <= 1'b0;
         prev_n <= 1'b1;
      end
      else
      begin
         prev_n <= level_n;
         fell <= prev_n & ~level_n;
         if (level_n)
         begin
            count <= {W{1'b0}};
            reached <= 1'b0;
         end
         else if (count >= limit)
            reached <= 1'b1;
         else
            count <= count + {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule

// *** mprs_properties.sv ***
// Checker of the power and reset sequencer ports
`timescale 1ns/1ns
module mprs_properties
#(
   parameter [31:0] PWRUP_CYCLES = 40,
   parameter [31:0] RST_MIN_CYCLES = 10,
   parameter [31:0] RST_PWRUP_CYCLES = 20
)
(
   input wire clk,
   input wire reset_n,
   input wire battery_supply,
   input wire power_on_request_n,
   input wire external_reset_n,
   input wire power_off_command,
   input wire io_supply_status,
   input wire module_ready,
   input wire core_reset_n,
   input wire ram_clear,
   input wire regulator_enable,
   input wire request_pullup_enable
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   reg [31:0] req_cnt;
   reg [31:0] low_cnt;
   reg [31:0] rst_cnt;
   reg rst_seen;
   // Short resets never clear RAM, so only a cleared restart counts
   always @(posedge clk or negedge reset_n)
      if (!reset_n)
      begin
         req_cnt <= 0;
         low_cnt <= 0;
         rst_cnt <= 0;
         rst_seen <= 0;
      end
      else
      begin
         req_cnt <= power_on_request_n ? 0 : req_cnt + 1;
         low_cnt <= external_reset_n ? 0 : low_cnt + 1;
         rst_cnt <= (!external_reset_n && low_cnt == 0) ? 0 : rst_cnt + 1;
         rst_seen <= io_supply_status && (rst_seen || ram_clear);
      end
   a_request_powers_on: assert property ($fell(power_on_request_n) && battery_supply
      && external_reset_n && !io_supply_status |-> ##[2:10] io_supply_status) else $error("no power-up");
   a_pwrup_period: assert property ($rose(module_ready) && !rst_seen
      |-> req_cnt >= PWRUP_CYCLES) else $error("ready too early");
   a_ready_needs_on: assert property (module_ready |-> io_supply_status
      && core_reset_n) else $error("ready while off");
   a_status_held_on: assert property ((!power_on_request_n && battery_supply
      && !power_off_command)[*4] ##0 io_supply_status |=> io_supply_status) else $error("dropped");
   a_clear_min_low: assert property ($rose(ram_clear) |-> low_cnt >= RST_MIN_CYCLES
      && !core_reset_n) else $error("early clear");
   a_rst_pwrup: assert property ($rose(module_ready) && rst_seen
      |-> rst_cnt >= RST_PWRUP_CYCLES) else $error("restart too early");
   a_off_stays_off: assert property (power_on_request_n[*4] ##0 !io_supply_status
      |=> !io_supply_status) else $error("powered on");
   a_req_high_off: assert property ((power_on_request_n && !external_reset_n)[*8]
      |-> !io_supply_status) else $error("still on");
   a_no_supply_off: assert property ((!battery_supply)[*3] |-> !io_supply_status
      && !regulator_enable && !request_pullup_enable) else $error("on without supply");
   cover property ($rose(module_ready));
   cover property ($rose(ram_clear));
   cover property ($fell(io_supply_status));
endmodule
bind mprs_sequencer mprs_properties #(.PWRUP_CYCLES(PWRUP_CYCLES),
   .RST_MIN_CYCLES(RST_MIN_CYCLES), .RST_PWRUP_CYCLES(RST_PWRUP_CYCLES)) u_chk (.*);

// *** mprs_sequencer.v ***
// Power-on and reset sequencer of the cellular module
// Behaviour
// - A low level on power_on_request_n switches the module on.
// - With battery_supply present the request line idles high through the internal pull-up.
// - After the power-on falling edge the module is fully powered no sooner than 2000 ms.
// - io_supply_status is low while off and high while on in any on mode.
// - io_supply_status stays on while power_on_request_n is low, even during a module reset, until power_off_command or loss of battery_supply.
// - Releasing the request alone never powers the module down; power_off_command does, then the line idles high.
// - A reset needs external_reset_n low for at least 10 ms with the request low, then restarts once external_reset_n is released.
// - After a reset the module comes up again without a new power-on request.
// - A reset clears the processor registers and the RAM contents.
// - external_reset_n is ignored while off and never powers the module on.
// - The module is off whenever the request is high while external_reset_n is held low, except during power-up and restart.
// - After the reset falling edge the module is operational no sooner than 38 ms.
`timescale 1ns/1ns
`include "mprs_consts.vh"
module mprs_sequencer
#(
   parameter [31:0] PWRUP_CYCLES = `MPRS_PWRUP_MS * `MPRS_CYC_PER_MS,
   parameter [31:0] RST_MIN_CYCLES = `MPRS_RST_MIN_MS * `MPRS_CYC_PER_MS,
   parameter [31:0] RST_PWRUP_CYCLES = `MPRS_RST_PWRUP_MS * `MPRS_CYC_PER_MS
)
(
   input wire clk,
   input wire reset_n,
   input wire battery_supply,
   input wire power_on_request_n,
   input wire external_reset_n,
   input wire power_off_command,
   output reg io_supply_status,
   output reg module_ready,
   output reg core_reset_n,
   output reg ram_clear,
   output reg regulator_enable,
   output reg request_pullup_enable
);
   reg rst_meta;
   reg rst_n;
   wire pwr_n_s;
   wire ext_n_s;
   wire pwr_long;
   wire rst_long;
   reg [2:0] state;
   reg [2:0] next_state;
   reg [31:0] wait_count;
   reg [31:0] next_wait_count;
   reg latched_off;
   reg next_latched_off;

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // Inputs idle high so a floating pad reads as no request
   mprs_sync #(.RESET_VAL(1'b1)) u_pwr_sync
   (
      .clk(clk),
      .rst_n(rst_n),
      .d(power_on_request_n),
      .q(pwr_n_s)
   );

   mprs_sync #(.RESET_VAL(1'b1)) u_rst_sync
   (
      .clk(clk),
      .rst_n(rst_n),
      .d(external_reset_n),
      .q(ext_n_s)
   );

   // A one-cycle glitch must not count as a request
   mprs_low_timer #(.W(`MPRS_CNT_W)) u_pwr_timer
   (
      .clk(clk),
      .rst_n(rst_n),
      .level_n(pwr_n_s),
      .limit(32'h0000_0001),
      .reached(pwr_long),
      .fell()
   );

   mprs_low_timer #(.W(`MPRS_CNT_W)) u_rst_timer
   (
      .clk(clk),
      .rst_n(rst_n),
      .level_n(ext_n_s),
      .limit(RST_MIN_CYCLES),
      .reached(rst_long),
      .fell()
   );

   always @*
   begin
      next_state = state;
      next_wait_count = wait_count;
      next_latched_off = latched_off;
      if (pwr_n_s)
         next_latched_off = 1'b0;
      case (state)
         `MPRS_ST_OFF:
         begin
            // Reset input plays no part here
            if (battery_supply && pwr_long && !latched_off)
            begin
               next_state = `MPRS_ST_POWERING;
               next_wait_count = 32'h0000_0000;
            end
         end
         `MPRS_ST_POWERING:
         begin
            if (wait_count >= PWRUP_CYCLES - 32'h0000_0001)
               next_state = `MPRS_ST_ON;
            else
               next_wait_count = wait_count + 32'h0000_0001;
         end
         `MPRS_ST_ON:
         begin
            // Request release is not a power-down
            if (power_off_command)
            begin
               next_state = `MPRS_ST_OFF;
               next_latched_off = ~pwr_n_s;
            end
            else if (!ext_n_s && pwr_n_s)
               next_state = `MPRS_ST_OFF;
            else if (!ext_n_s)
               next_state = `MPRS_ST_RESETTING;
         end
         `MPRS_ST_RESETTING:
         begin
            if (pwr_n_s)
               next_state = `MPRS_ST_OFF;
            else if (rst_long)
            begin
               next_state = `MPRS_ST_WAIT_REL;
               next_wait_count = RST_MIN_CYCLES;
            end
            else if (ext_n_s)
               next_state = `MPRS_ST_ON;
         end
         `MPRS_ST_WAIT_REL:
         begin
            // Count continues from the reset edge toward 38 ms
            if (pwr_n_s && !ext_n_s)
               next_state = `MPRS_ST_OFF;
            else if (ext_n_s)
               next_state = `MPRS_ST_RESTART;
            else if (wait_count < RST_PWRUP_CYCLES)
               next_wait_count = wait_count + 32'h0000_0001;
         end
         `MPRS_ST_RESTART:
         begin
            if (wait_count >= RST_PWRUP_CYCLES - 32'h0000_0001)
               next_state = `MPRS_ST_ON;
            else
               next_wait_count = wait_count + 32'h0000_0001;
         end
         default:
            next_state = `MPRS_ST_OFF;
      endcase
      if (!battery_supply)
         next_state = `MPRS_ST_OFF;
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= `MPRS_ST_OFF;
         wait_count <= 32'h0000_0000;
         latched_off <= 1'b0;
         io_supply_status <= 1'b0;
         module_ready <= 1'b0;
         core_reset_n <= 1'b0;
         ram_clear <= 1'b0;
         regulator_enable <= 1'b0;
         request_pullup_enable <= 1'b0;
      end
      else
      begin
         state <= next_state;
         wait_count <= next_wait_count;
         latched_off <= next_latched_off;
         regulator_enable <= battery_supply;
         request_pullup_enable <= battery_supply;
         io_supply_status <= (next_state != `MPRS_ST_OFF);
         module_ready <= (next_state == `MPRS_ST_ON);
         // Core held in reset while powering up or being reset
         core_reset_n <= (next_state == `MPRS_ST_ON);
         ram_clear <= (next_state == `MPRS_ST_WAIT_REL);
      end
   end
endmodule

// *** mprs_sync.v ***
// Two-stage synchroniser for one level input
`timescale 1ns/1ns
module mprs_sync
#(
   parameter RESET_VAL = 1'b1
)
(
   input wire clk,
   input wire rst_n,
   input wire d,
   output reg q
);
   reg meta;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta <= RESET_VAL;
         q <= RESET_VAL;
      end
      else
      begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// *** test_module_power_reset_sequencer.sv ***
// Self-checking bench of the power and reset sequencer
`timescale 1ns/1ns
module test_module_power_reset_sequencer;
   logic clk = 0, reset_n = 0, battery_supply = 1, power_off_command = 0;
   logic pull_req = 0, pull_rst = 0;
   wire power_on_request_n, external_reset_n, io_supply_status, module_ready;
   wire core_reset_n, ram_clear, regulator_enable, request_pullup_enable;
   int fails = 0, n_tests = 0, n;
   initial forever #4 clk = ~clk;
   mprs_host_model host (.pull_req(pull_req), .pull_rst(pull_rst),
      .power_on_request_n(power_on_request_n), .external_reset_n(external_reset_n));
   mprs_sequencer #(.PWRUP_CYCLES(40), .RST_MIN_CYCLES(10), .RST_PWRUP_CYCLES(20)) dut (.*);
   task check(input string what, input logic seen, input logic exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s expected %b seen %b", what, exp, seen);
      end
   endtask
   task tally_and_finish;
      if (fails == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task tick(input int c);
      repeat (c) @(posedge clk);
   endtask
   // Sampled at the falling edge so registered outputs have settled
   task wait_ready(output int k);
      k = 0;
      while (module_ready !== 1'b1)
      begin
         @(negedge clk);
         k++;
         if (k > 300)
         begin
            fails++;
            tally_and_finish;
         end
      end
   endtask
   task power_on;
      tick(1);
      pull_req <= 0;
      tick(4);
      pull_req <= 1;
      wait_ready(n);
      check("pwrup", n >= 40, 1'b1);
      check("on", io_supply_status, 1'b1);
   endtask
   task reset_pulse(input int len);
      tick(1);
      pull_rst <= 1;
      tick(len);
      @(negedge clk);
      check("held", io_supply_status, 1'b1);
      check("clear", ram_clear, len > 12);
      check("core", core_reset_n, 1'b0);
      tick(1);
      pull_rst <= 0;
      wait_ready(n);
      check("restart", n + len >= 20, len > 12);
   endtask
   task off_check(input string what);
      tick(8);
      @(negedge clk);
      check(what, io_supply_status, 1'b0);
   endtask
   task reset_low_while(input logic drop);
      tick(1);
      pull_rst <= 1;
      tick(12);
      pull_req <= drop ? 1'b0 : pull_req;
      off_check("off in reset");
      tick(1);
      pull_rst <= 0;
   endtask
   task supply_loss;
      tick(1);
      battery_supply <= 0;
      tick(4);
      @(negedge clk);
      check("supply off", io_supply_status, 1'b0);
      check("regulator", regulator_enable, 1'b0);
      check("pullup off", request_pullup_enable, 1'b0);
      tick(1);
      battery_supply <= 1;
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      reset_n <= 1;
      tick(4);
      @(negedge clk);
      check("pullup", request_pullup_enable, 1'b1);
      reset_low_while(0);
      power_on;
      reset_pulse(4);
      reset_pulse(16);
      tick(1);
      power_off_command <= 1;
      tick(1);
      power_off_command <= 0;
      off_check("cmd off");
      reset_low_while(0);
      power_on;
      reset_low_while(1);
      power_on;
      supply_loss;
      tally_and_finish;
   end
endmodule
